/* hw/lsar_pkg.sv */
// ============================================================
// load setpoint / alarm relay constants
// ============================================================
package lsar_pkg;

  // ==========================================================
  // bus geometry
  // ==========================================================
  localparam int LSAR_DATA_W    = 32;
  localparam int LSAR_ADDR_W    = 8;
  localparam int LSAR_NUM_ZONES = 4;
  localparam int LSAR_NUM_THR   = 8;
  localparam int LSAR_THR_IDX_W = 3;
  localparam int LSAR_LOAD_W    = 24;

  // ==========================================================
  // register byte offsets
  // ==========================================================
  localparam logic [LSAR_ADDR_W-1:0] LSAR_OFF_CTRL     = 8'h00;
  localparam logic [LSAR_ADDR_W-1:0] LSAR_OFF_STATUS   = 8'h04;
  localparam logic [LSAR_ADDR_W-1:0] LSAR_OFF_SAMPLE   = 8'h08;
  localparam logic [LSAR_ADDR_W-1:0] LSAR_OFF_IRQ_STAT = 8'h0C;
  localparam logic [LSAR_ADDR_W-1:0] LSAR_OFF_IRQ_MASK = 8'h10;
  localparam logic [LSAR_ADDR_W-1:0] LSAR_OFF_THR_BASE = 8'h20;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int LSAR_CTRL_MODE_BIT  = 0;
  localparam int LSAR_CTRL_EN_BIT    = 1;
  localparam int LSAR_CTRL_W         = 2;
  localparam logic [LSAR_CTRL_W-1:0] LSAR_CTRL_RST = 2'h0;
  localparam int LSAR_STAT_ALARM_BIT = 4;
  localparam int LSAR_STAT_ORDER_BIT = 5;
  localparam int LSAR_STAT_W         = 6;
  localparam int LSAR_IRQ_ALARM_BIT  = 4;
  localparam int LSAR_IRQ_ORDER_BIT  = 5;
  localparam int LSAR_IRQ_SAMPLE_BIT = 6;
  localparam int LSAR_IRQ_W          = 7;
  localparam logic [LSAR_IRQ_W-1:0] LSAR_IRQ_RST = 7'h00;

  // ==========================================================
  // threshold slots and reset values
  // ==========================================================
  localparam int LSAR_THR_AL_TOP    = 4;
  localparam int LSAR_THR_AL_UPPER  = 5;
  localparam int LSAR_THR_AL_LOWER  = 6;
  localparam int LSAR_THR_AL_BOTTOM = 7;
  localparam logic [LSAR_DATA_W-1:0] LSAR_THR_RST [0:LSAR_NUM_THR-1] = '{
    32'h0000_03E8, 32'h0000_07D0, 32'h0000_0BB8, 32'h0000_0FA0,
    32'h0000_1B58, 32'h0000_1388, 32'h0000_0BB8, 32'h0000_03E8
  };

  typedef enum logic {
    LSAR_MODE_SETPOINT = 1'b0,
    LSAR_MODE_ALARM    = 1'b1
  } lsar_mode_e;

endpackage

/* hw/lsar_zone_cmp.sv */
`timescale 1ns/1ps
// ============================================================
// one zone window: strict signed compare on both edges
// ============================================================
module lsar_zone_cmp #(
  parameter int LOAD_W = 24
) (
  input  wire logic [LOAD_W-1:0] sample,
  input  wire logic [LOAD_W-1:0] lo_limit,
  input  wire logic [LOAD_W-1:0] hi_limit,
  input  wire logic              use_lo,
  input  wire logic              use_hi,
  output logic                   in_zone
);

  logic above_lo;
  logic below_hi;

  // equality lands outside the window on either edge
  always_comb begin
    above_lo = $signed(sample) > $signed(lo_limit);
    below_hi = $signed(sample) < $signed(hi_limit);
    in_zone  = (!use_lo || above_lo) && (!use_hi || below_hi);
  end

endmodule

/* hw/lsar_relay_ctrl.sv */
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module lsar_relay_ctrl #(
  parameter int LOAD_W = lsar_pkg::LSAR_LOAD_W
) (
  input  wire logic                             mclk,
  input  wire logic                             rst_b,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [lsar_pkg::LSAR_ADDR_W-1:0] paddr,
  input  wire logic [lsar_pkg::LSAR_DATA_W-1:0] pwdata,
  output logic      [lsar_pkg::LSAR_DATA_W-1:0] prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [LOAD_W-1:0]                load_value,
  input  wire logic                             load_valid,
  output logic      [lsar_pkg::LSAR_NUM_ZONES-1:0] relay_close,
  output logic      [lsar_pkg::LSAR_NUM_ZONES-1:0] zone_symbol,
  output logic                                  alarm_sound,
  output logic                                  warning_msg,
  output logic                                  irq
);
  import lsar_pkg::*;

  // ==========================================================
  // elaboration checks
  // ==========================================================
  if (LOAD_W < 2 || LOAD_W > LSAR_DATA_W) begin : g_bad_width
    $error("LOAD_W must lie between 2 and 32");
  end

  // ==========================================================
  // declarations
  // ==========================================================
  logic [LSAR_CTRL_W-1:0]    ctrl_reg;
  logic [LOAD_W-1:0]         thr_reg [0:LSAR_NUM_THR-1];
  logic [LOAD_W-1:0]         sample_reg;
  logic [LSAR_IRQ_W-1:0]     irq_stat_reg;
  logic [LSAR_IRQ_W-1:0]     irq_stat_next;
  logic [LSAR_IRQ_W-1:0]     irq_mask_reg;
  logic [LSAR_IRQ_W-1:0]     irq_mask_next;
  logic [LSAR_IRQ_W-1:0]     irq_event;
  logic [LSAR_NUM_ZONES-1:0] relay_reg;
  logic [LSAR_NUM_ZONES-1:0] relay_next;
  logic [LSAR_NUM_ZONES-1:0] in_zone;
  logic                      alarm_reg;
  logic                      alarm_next;
  logic                      warn_reg;
  logic                      order_err;
  logic                      order_err_reg;
  logic [LSAR_DATA_W-1:0]    prdata_reg;
  logic                      pready_reg;
  logic                      pslverr_reg;
  logic                      irq_reg;
  logic [LSAR_DATA_W-1:0]    rd_mux;
  logic                      addr_ok;
  logic                      thr_hit;
  logic [LSAR_THR_IDX_W-1:0] thr_idx;
  logic                      apb_setup;
  logic                      apb_write;
  logic [LOAD_W-1:0]         cmp_value;
  lsar_mode_e                mode;
  logic                      enabled;

  assign mode      = lsar_mode_e'(ctrl_reg[LSAR_CTRL_MODE_BIT]);
  assign enabled   = ctrl_reg[LSAR_CTRL_EN_BIT];
  assign apb_setup = psel && !penable;
  // a write lands only on the edge that completes the access phase
  assign apb_write = psel && penable && pready_reg && pwrite && addr_ok;
  assign thr_idx   = paddr[LSAR_THR_IDX_W+1:2];

  // ==========================================================
  // address decode and read mux
  // ==========================================================
  always_comb begin
    rd_mux  = '0;
    addr_ok = 1'b0;
    thr_hit = 1'b0;
    if (paddr == LSAR_OFF_CTRL) begin
      addr_ok = 1'b1;
      rd_mux  = 32'(ctrl_reg);
    end else if (paddr == LSAR_OFF_STATUS) begin
      addr_ok = 1'b1;
      rd_mux  = 32'({order_err_reg, alarm_reg, relay_reg});
    end else if (paddr == LSAR_OFF_SAMPLE) begin
      addr_ok = 1'b1;
      rd_mux  = 32'(sample_reg);
    end else if (paddr == LSAR_OFF_IRQ_STAT) begin
      addr_ok = 1'b1;
      rd_mux  = 32'(irq_stat_reg);
    end else if (paddr == LSAR_OFF_IRQ_MASK) begin
      addr_ok = 1'b1;
      rd_mux  = 32'(irq_mask_reg);
    end else if (paddr[7:5] == LSAR_OFF_THR_BASE[7:5] && paddr[1:0] == 2'h0) begin
      addr_ok = 1'b1;
      thr_hit = 1'b1;
      rd_mux  = 32'(thr_reg[thr_idx]);
    end
  end

  // ==========================================================
  // apb answer: one wait-free access phase
  // ==========================================================
  // read data is captured in setup so prdata comes straight off a flop
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && !addr_ok;
      if (apb_setup && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // ==========================================================
  // control register
  // ==========================================================
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_reg <= LSAR_CTRL_RST;
    end else if (apb_write && paddr == LSAR_OFF_CTRL) begin
      ctrl_reg <= pwdata[LSAR_CTRL_W-1:0];
    end
  end

  // ==========================================================
  // threshold storage, one slot per entry
  // ==========================================================
  for (genvar gi = 0; gi < LSAR_NUM_THR; gi++) begin : g_thr
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        thr_reg[gi] <= LOAD_W'(LSAR_THR_RST[gi]);
      end else if (apb_write && thr_hit && thr_idx == LSAR_THR_IDX_W'(gi)) begin
        thr_reg[gi] <= pwdata[LOAD_W-1:0];
      end
    end
  end

  // ==========================================================
  // load sample
  // ==========================================================
  // a fresh sample is compared in its own cycle, no extra latency
  assign cmp_value = load_valid ? load_value : sample_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sample_reg <= '0;
    end else if (load_valid) begin
      sample_reg <= load_value;
    end
  end

  // ==========================================================
  // zone windows
  // ==========================================================
  for (genvar gz = 0; gz < LSAR_NUM_ZONES; gz++) begin : g_zone
    logic [LOAD_W-1:0] lo_lim;
    logic [LOAD_W-1:0] hi_lim;
    logic              use_lo;
    logic              use_hi;

    // pick the two edges of this zone for the selected mode
    always_comb begin
      lo_lim = thr_reg[(gz == 0) ? 0 : gz - 1];
      hi_lim = thr_reg[gz];
      use_lo = (gz != 0);
      use_hi = 1'b1;
      if (mode == LSAR_MODE_ALARM) begin
        case (gz)
          0: begin
            lo_lim = thr_reg[LSAR_THR_AL_TOP];
            hi_lim = thr_reg[LSAR_THR_AL_TOP];
            use_lo = 1'b0;
          end
          1: begin
            lo_lim = thr_reg[LSAR_THR_AL_UPPER];
            hi_lim = thr_reg[LSAR_THR_AL_TOP];
            use_lo = 1'b1;
          end
          2: begin
            lo_lim = thr_reg[LSAR_THR_AL_BOTTOM];
            hi_lim = thr_reg[LSAR_THR_AL_LOWER];
            use_lo = 1'b1;
          end
          default: begin
            lo_lim = thr_reg[LSAR_THR_AL_BOTTOM];
            hi_lim = thr_reg[LSAR_THR_AL_BOTTOM];
            use_lo = 1'b0;
          end
        endcase
      end
    end

    lsar_zone_cmp #(
      .LOAD_W (LOAD_W)
    ) u_cmp (
      .sample   (cmp_value),
      .lo_limit (lo_lim),
      .hi_limit (hi_lim),
      .use_lo   (use_lo),
      .use_hi   (use_hi),
      .in_zone  (in_zone[gz])
    );
  end

  // ==========================================================
  // relays, symbols and annunciators
  // ==========================================================
  // a disabled block opens every relay: the safe state after reset
  assign relay_next = enabled ? in_zone : '0;
  assign alarm_next = enabled && (mode == LSAR_MODE_ALARM) && (|in_zone);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      relay_reg <= '0;
      alarm_reg <= 1'b0;
      warn_reg  <= 1'b0;
    end else begin
      relay_reg <= relay_next;
      alarm_reg <= alarm_next;
      // one warning pulse whenever any alarm zone is newly entered, however many at once
      warn_reg  <= alarm_next && (|(relay_next & ~relay_reg));
    end
  end

  // ==========================================================
  // limit order watch
  // ==========================================================
  // flags a misordered set of alarm limits; zones still follow the
  // limits as written, so overlapping zones are possible then
  always_comb begin
    order_err = !(($signed(thr_reg[LSAR_THR_AL_TOP]) > $signed(thr_reg[LSAR_THR_AL_UPPER]))
               && ($signed(thr_reg[LSAR_THR_AL_UPPER]) > $signed(thr_reg[LSAR_THR_AL_LOWER]))
               && ($signed(thr_reg[LSAR_THR_AL_LOWER]) > $signed(thr_reg[LSAR_THR_AL_BOTTOM])));
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      order_err_reg <= 1'b0;
    end else begin
      order_err_reg <= order_err;
    end
  end

  // ==========================================================
  // interrupt status and mask
  // ==========================================================
  // set wins over a write-one-to-clear in the same cycle
  always_comb begin
    irq_event = '0;
    irq_event[LSAR_NUM_ZONES-1:0]   = relay_next & ~relay_reg;
    irq_event[LSAR_IRQ_ALARM_BIT]   = alarm_next && !alarm_reg;
    irq_event[LSAR_IRQ_ORDER_BIT]   = order_err && !order_err_reg;
    irq_event[LSAR_IRQ_SAMPLE_BIT]  = load_valid;
    irq_stat_next = irq_stat_reg;
    if (apb_write && paddr == LSAR_OFF_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~pwdata[LSAR_IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_event;
    irq_mask_next = irq_mask_reg;
    if (apb_write && paddr == LSAR_OFF_IRQ_MASK) begin
      irq_mask_next = pwdata[LSAR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_stat_reg <= LSAR_IRQ_RST;
      irq_mask_reg <= LSAR_IRQ_RST;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= |(irq_stat_next & irq_mask_next);
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign relay_close = relay_reg;
  assign zone_symbol = relay_reg;
  assign alarm_sound = alarm_reg;
  assign warning_msg = warn_reg;
  assign irq         = irq_reg;

  // ==========================================================
  // assertions
  // ==========================================================
  // reference compares, written apart from the zone muxing
  logic signed [LOAD_W-1:0] cv;
  logic                     exp_sp [0:3];
  logic                     exp_al [0:3];
  logic                     sp_on;
  logic                     al_on;

  always_comb begin
    cv        = $signed(cmp_value);
    exp_sp[0] = cv < $signed(thr_reg[0]);
    exp_sp[1] = cv > $signed(thr_reg[0]) && cv < $signed(thr_reg[1]);
    exp_sp[2] = cv > $signed(thr_reg[1]) && cv < $signed(thr_reg[2]);
    exp_sp[3] = cv > $signed(thr_reg[2]) && cv < $signed(thr_reg[3]);
    exp_al[0] = cv < $signed(thr_reg[4]);
    exp_al[1] = cv < $signed(thr_reg[4]) && cv > $signed(thr_reg[5]);
    exp_al[2] = cv < $signed(thr_reg[6]) && cv > $signed(thr_reg[7]);
    exp_al[3] = cv < $signed(thr_reg[7]);
    sp_on     = enabled && mode == LSAR_MODE_SETPOINT;
    al_on     = enabled && mode == LSAR_MODE_ALARM;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready_reg ##1 !pready_reg;
  endsequence

  a_sp_zone_one: assert property (sp_on |=> relay_close[0] == $past(exp_sp[0]))
    else $error("setpoint zone 1 relay wrong");
  a_sp_zone_two: assert property (sp_on |=> relay_close[1] == $past(exp_sp[1]))
    else $error("setpoint zone 2 relay wrong");
  a_sp_zone_three: assert property (sp_on |=> relay_close[2] == $past(exp_sp[2]))
    else $error("setpoint zone 3 relay wrong");
  a_sp_zone_four: assert property (sp_on |=> zone_symbol[3] == $past(exp_sp[3]))
    else $error("setpoint zone 4 symbol wrong");
  a_al_zone_one: assert property (al_on && exp_al[0] |=> relay_close[0] && alarm_sound)
    else $error("alarm zone 1 not signalled");
  a_al_zone_two: assert property (al_on |=> relay_close[1] == $past(exp_al[1]))
    else $error("alarm zone 2 relay wrong");
  a_al_zone_three: assert property (al_on |=> relay_close[2] == $past(exp_al[2]))
    else $error("alarm zone 3 relay wrong");
  a_al_zone_four: assert property (al_on && exp_al[3] |=> relay_close[3] && alarm_sound)
    else $error("alarm zone 4 not signalled");
  a_equal_outside: assert property (sp_on && cv == $signed(thr_reg[0])
    |=> !relay_close[0] && !relay_close[1])
    else $error("load equal to limit counted inside");
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("apb answer not one cycle");
  a_irq_level: assert property (irq == (|$past(irq_stat_next & irq_mask_next)))
    else $error("irq level disagrees with status");

endmodule

/* sim/lsar_annunciator_model.sv */
`timescale 1ns/1ps
// ============================================================
// relay contacts, buzzer and display lamps on the far side
// ============================================================
module lsar_annunciator_model (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [3:0] relay_close,
  input  wire logic [3:0] zone_symbol,
  input  wire logic       alarm_sound,
  input  wire logic       warning_msg,
  output logic      [3:0] contact_state,
  output logic      [3:0] lamp_state,
  output logic            buzzer_on,
  output int              warn_count
);
  // contacts follow the coil with no bounce; a real relay would lag a few ms
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      contact_state <= 4'h0;
      lamp_state    <= 4'h0;
      buzzer_on     <= 1'b0;
      warn_count    <= 0;
    end else begin
      contact_state <= relay_close;
      lamp_state    <= zone_symbol;
      buzzer_on     <= alarm_sound;
      warn_count    <= warn_count + (warning_msg ? 1 : 0);
    end
  end
endmodule

/* sim/tb_load_setpoint_alarm_relays.sv */
`timescale 1ns/1ps
module tb_load_setpoint_alarm_relays;
  import lsar_pkg::*;
  localparam int LOAD_W = 24;
  logic              mclk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [LOAD_W-1:0] load_value;
  logic              load_valid, vld_d, err, alarm_sound, warning_msg, buzzer_on;
  logic [3:0]        relay_close, zone_symbol, contact_state, lamp_state, prev_r;
  logic [5:0]        exp_q[$];
  logic [5:0]        e;
  int                n_errors, comparisons, warn_count, thr[8], last_v, v;
  logic              md, en;

  lsar_relay_ctrl #(.LOAD_W(LOAD_W)) lsar_relay_ctrl_inst (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .load_value(load_value), .load_valid(load_valid),
    .relay_close(relay_close), .zone_symbol(zone_symbol),
    .alarm_sound(alarm_sound), .warning_msg(warning_msg), .irq(irq));

  lsar_annunciator_model lsar_annunciator_model_inst (
    .mclk(mclk), .rst_b(rst_b), .relay_close(relay_close), .zone_symbol(zone_symbol),
    .alarm_sound(alarm_sound), .warning_msg(warning_msg), .contact_state(contact_state),
    .lamp_state(lamp_state), .buzzer_on(buzzer_on), .warn_count(warn_count));

  // ============================================================
  // reporting
  // ============================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("counts: comparisons %0d errors %0d warnings %0d", comparisons, n_errors,
             warn_count);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ============================================================
  // expected zones: strict signed compares, equal stays outside
  // ============================================================
  function automatic logic [5:0] calc(input int x, input logic [3:0] pr);
    logic [3:0] r;
    if (!md) begin
      r[0] = x < thr[0];
      r[1] = x > thr[0] && x < thr[1];
      r[2] = x > thr[1] && x < thr[2];
      r[3] = x > thr[2] && x < thr[3];
    end else begin
      r[0] = x < thr[4];
      r[1] = x > thr[5] && x < thr[4];
      r[2] = x > thr[7] && x < thr[6];
      r[3] = x < thr[7];
    end
    if (!en) r = 4'h0;
    return {md & |(r & ~pr), md & |r, r};
  endfunction

  // ============================================================
  // bus and sample drivers
  // ============================================================
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // answer is read at the rising edge, before that edge updates the slave flops;
    // the slave answers when it likes; the wait ends on pready or at the bound of 50 cycles
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50) begin
      check("pready", 0, 1);
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
    check("pslverr", err, 1'b0);
  endtask

  // held sample is re-compared after every config change
  task automatic set_ctrl(input logic m, input logic n);
    apb(1'b1, LSAR_OFF_CTRL, {30'h0, n, m});
    md = m;
    en = n;
    prev_r = 4'(calc(last_v, 4'h0));
    repeat (2) @(posedge mclk);
  endtask

  // own copy of the note: the watcher rewrites e at the falling edge in between
  task automatic send(input int x);
    logic [5:0] ex;
    ex = calc(x, prev_r);
    @(posedge mclk);
    load_valid <= 1'b1;
    load_value <= LOAD_W'(x);
    exp_q.push_back(ex);
    prev_r = ex[3:0];
    last_v = x;
  endtask

  task automatic idle();
    @(posedge mclk);
    load_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  // ============================================================
  // result watcher: one note per sample, one cycle later
  // ============================================================
  always @(posedge mclk) vld_d <= load_valid & rst_b;

  always @(negedge mclk) begin
    if (vld_d) begin
      if (exp_q.size() == 0) begin
        check("queue", 0, 1);
      end else begin
        e = exp_q.pop_front();
        check("relay_close", relay_close, e[3:0]);
        check("zone_symbol", zone_symbol, e[3:0]);
        check("alarm_sound", alarm_sound, e[4]);
        check("warning_msg", warning_msg, e[5]);
      end
    end
  end

  // clock and a global watchdog
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    stop_test();
  end

  // ============================================================
  // main sequence
  // ============================================================
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; load_value = '0; load_valid = 1'b0;
    n_errors = 0; comparisons = 0; last_v = 0; md = 1'b0; en = 1'b0; prev_r = 4'h0;
    void'($urandom(49));
    for (int i = 0; i < 8; i++) thr[i] = int'(LSAR_THR_RST[i]);
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    // reset values and an unmapped address
    rdchk("ctrl", LSAR_OFF_CTRL, 32'(LSAR_CTRL_RST));
    rdchk("irq_mask", LSAR_OFF_IRQ_MASK, 32'(LSAR_IRQ_RST));
    for (int i = 0; i < 8; i++) rdchk("thr", LSAR_OFF_THR_BASE + 8'(4 * i), LSAR_THR_RST[i]);
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped err", err, 1'b1);
    $display("test reset_and_map done");
    // every threshold hit exactly and one step either side, back to back
    for (int m = 0; m < 2; m++) begin
      set_ctrl(m[0], 1'b1);
      for (int i = 0; i < 8; i++)
        for (int d = -1; d <= 1; d++) send(thr[i] + d);
      idle();
    end
    $display("test boundaries done");
    // new limits, alarm set kept strictly descending
    thr = '{200, 400, 600, 800, 900, 700, 300, 100};
    for (int i = 0; i < 8; i++) apb(1'b1, LSAR_OFF_THR_BASE + 8'(4 * i), 32'(thr[i]));
    for (int m = 0; m < 2; m++) begin
      set_ctrl(m[0], 1'b1);
      for (int k = 0; k < 40; k++) begin
        v = int'($urandom_range(1200)) - 100;
        send(v);
      end
      idle();
    end
    $display("test random done");
    // interrupt masked, raised, then cleared
    apb(1'b1, LSAR_OFF_IRQ_MASK, 32'h0);
    send(250);
    idle();
    check("irq masked", irq, 1'b0);
    rdchk("sample", LSAR_OFF_SAMPLE, 32'd250);
    rdchk("status", LSAR_OFF_STATUS, 32'(calc(250, 4'hF)));
    apb(1'b1, LSAR_OFF_IRQ_MASK, 32'h1 << LSAR_IRQ_SAMPLE_BIT);
    idle();
    check("irq raised", irq, 1'b1);
    apb(1'b0, LSAR_OFF_IRQ_STAT, 32'h0);
    check("irq_stat sample", rd[LSAR_IRQ_SAMPLE_BIT], 1'b1);
    // the limit rewrite passed through a misordered set on its way
    check("irq_stat order", rd[LSAR_IRQ_ORDER_BIT], 1'b1);
    apb(1'b1, LSAR_OFF_IRQ_STAT, 32'h1 << LSAR_IRQ_SAMPLE_BIT);
    idle();
    check("irq cleared", irq, 1'b0);
    $display("test irq done");
    // disabled block keeps every relay open
    set_ctrl(1'b1, 1'b0);
    send(50);
    send(650);
    idle();
    check("contacts", contact_state, 4'h0);
    check("lamps", lamp_state, 4'h0);
    check("buzzer", buzzer_on, 1'b0);
    $display("test disable done");
    check("queue left", exp_q.size(), 0);
    stop_test();
  end
endmodule
